/* File: src/obt_tuner.sv */
// Oscillator bias lock tuner: decodes the auto-tune enable telecommand,
// runs the bias lock search and the pre-calibration trim, drives the bias
// into the sensor unit control word.
// Assumes command words, table-init, calibration and power flags come from
// logic on core_clk_in; the phase-error code comes from outside the domain.
//
// Notes on behaviour
// - Accept only identifier 71, category 12
// - Packet length field must equal 7
// - Acknowledge field must be 0001
// - Packet type must be 192
// - Subtype 21 is the tuning enable command
// - Data 0 disables, 1 enables tuning
// - Tuning enable defaults to enabled
// - Valid command stores value in enable flag
// - Bias loads 4 after reset
// - After table init, bias set to 3
// - Search step adds one, 15 wraps 0
// - Wait one second, then sample phase
// - In-window phase keeps bias, ends search
// - Out-of-window phase repeats the step
// - After 32 failed iterations bias is 4
// - Bias holds until command or reset
// - Enabled and powered: check before calibration
// - Phase below window decrements bias
// - Phase above window increments, then calibrate
// - Trim only at calibration, one count
// - Bias on word bits 16-19, readback reversed
// - Reset forces the enable flag on
//
// The register addresses and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
`include "obt_map.svh"

module obt_tuner import obt_pkg::*; #(
  parameter int SETTLE_CYCLES = `OBT_CLK_HZ / `OBT_MS_PER_S * `OBT_SETTLE_MS
) (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic [15:0] cmd_word_in,
  input wire logic cmd_word_valid_in,
  input wire logic cmd_first_in,
  input wire logic [11:0] phase_err_in,
  input wire logic table_init_done_in,
  input wire logic cal_req_in,
  input wire logic cts_powered_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_we_in,
  input wire logic reg_re_in,
  output logic [31:0] reg_rdata_out,
  output logic [31:0] sensor_unit_control_word_out,
  output logic [15:0] control_word_housekeeping_readback_out,
  output logic auto_tune_enable_parameter_out,
  output logic cal_go_out,
  output logic search_busy_out
);

  localparam logic [24:0] SETTLE_LAST = 25'(SETTLE_CYCLES - 1);

  localparam obt_regs_t RESET_REGS = '{
    state: OBT_WAIT_INIT,
    bias: `OBT_BIAS_RESET,
    enable: `OBT_ENABLE_RESET,
    iter: 6'h00,
    settle_cnt: 25'h0000000,
    phase_meta: 12'h000,
    phase_sync: 12'h000,
    phase_last: 12'h000,
    locked: 1'h0,
    failed: 1'h0,
    word_idx: 3'h0,
    cmd_ok: 1'h0,
    cmd_value: 1'h0,
    cmd_accepted: 8'h00,
    cmd_rejected: 8'h00,
    cal_go: 1'h0,
    rdata: 32'h00000000
  };

  obt_regs_t st_ff;
  obt_regs_t nxt_st;

  function automatic logic below_window(input logic [11:0] code);
    below_window = code < `OBT_WIN_LOW;
  endfunction

  function automatic logic above_window(input logic [11:0] code);
    above_window = code > `OBT_WIN_HIGH;
  endfunction

  // Per-word header checks; checksum word is not verified here
  function automatic logic word_valid(input logic [2:0] idx, input logic [15:0] w);
    case (idx)
      3'h0: word_valid = w[10:4] == `OBT_APID && w[3:0] == `OBT_CATEGORY;
      3'h1: word_valid = w[13:11] == `OBT_SEQ_SOURCE;
      3'h2: word_valid = w == `OBT_PKT_LENGTH;
      3'h3: word_valid = w[11:8] == `OBT_ACK && w[7:0] == `OBT_PKT_TYPE;
      3'h4: word_valid = w[15:8] == `OBT_PKT_SUBTYPE;
      3'h5: word_valid = w[15:1] == 15'h0000;
      default: word_valid = 1'h1;
    endcase
  endfunction

  logic [31:0] ctrl_word;
  logic [15:0] hk_word;
  logic [2:0] cur_idx;

  always_comb begin
    ctrl_word = 32'h00000000;
    ctrl_word[`OBT_CW_BIAS_LSB +: 4] = st_ff.bias;
    hk_word = 16'h0000;
    for (int i = 0; i < 4; i++) begin
      hk_word[`OBT_HK_BIAS_MSB - i] = st_ff.bias[i];
    end
  end

  assign cur_idx = cmd_first_in ? 3'h0 : st_ff.word_idx;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.cal_go = 1'h0;

    // Phase code crosses in as a bus; it is read after a long settle, and by the trim at a calibration request in hold while enabled and powered
    nxt_st.phase_meta = phase_err_in;
    nxt_st.phase_sync = st_ff.phase_meta;

    // Command word stream
    if (cmd_word_valid_in) begin
      if (cur_idx == `OBT_LAST_WORD) begin
        nxt_st.word_idx = 3'h0;
        if (st_ff.cmd_ok) begin
          nxt_st.enable = st_ff.cmd_value;
          nxt_st.cmd_accepted = st_ff.cmd_accepted + 8'h01;
        end else begin
          nxt_st.cmd_rejected = st_ff.cmd_rejected + 8'h01;
        end
      end else begin
        nxt_st.word_idx = cur_idx + 3'h1;
        nxt_st.cmd_ok = (cmd_first_in ? 1'h1 : st_ff.cmd_ok) & word_valid(cur_idx, cmd_word_in);
        if (cur_idx == 3'h5) begin
          nxt_st.cmd_value = cmd_word_in[0];
        end
      end
    end

    // Lock search
    case (st_ff.state)
      OBT_WAIT_INIT: begin
        if (table_init_done_in) begin
          nxt_st.bias = `OBT_BIAS_START;
          nxt_st.iter = 6'h00;
          nxt_st.locked = 1'h0;
          nxt_st.failed = 1'h0;
          nxt_st.state = OBT_STEP;
        end
      end
      OBT_STEP: begin
        nxt_st.bias = st_ff.bias + 4'h1;
        nxt_st.iter = st_ff.iter + 6'h01;
        nxt_st.settle_cnt = 25'h0000000;
        nxt_st.state = OBT_SETTLE;
      end
      OBT_SETTLE: begin
        if (st_ff.settle_cnt == SETTLE_LAST) begin
          nxt_st.state = OBT_SAMPLE;
        end else begin
          nxt_st.settle_cnt = st_ff.settle_cnt + 25'h0000001;
        end
      end
      OBT_SAMPLE: begin
        nxt_st.phase_last = st_ff.phase_sync;
        if (!below_window(st_ff.phase_sync) && !above_window(st_ff.phase_sync)) begin
          nxt_st.locked = 1'h1;
          nxt_st.state = OBT_HOLD;
        end else if (st_ff.iter == `OBT_MAX_ITER) begin
          nxt_st.bias = `OBT_BIAS_FAIL;
          nxt_st.failed = 1'h1;
          nxt_st.state = OBT_HOLD;
        end else begin
          nxt_st.state = OBT_STEP;
        end
      end
      OBT_HOLD: begin
        // Bias stays put here except for trim or a manual write
        nxt_st.state = OBT_HOLD;
      end
      default: begin
        nxt_st.state = OBT_WAIT_INIT;
      end
    endcase

    // Calibration always proceeds; trim only once the search has settled
    if (cal_req_in) begin
      nxt_st.cal_go = 1'h1;
      if (st_ff.state == OBT_HOLD && st_ff.enable && cts_powered_in) begin
        nxt_st.phase_last = st_ff.phase_sync;
        if (below_window(st_ff.phase_sync) && st_ff.bias != `OBT_BIAS_MIN) begin
          nxt_st.bias = st_ff.bias - 4'h1;
        end else if (above_window(st_ff.phase_sync) && st_ff.bias != `OBT_BIAS_MAX) begin
          nxt_st.bias = st_ff.bias + 4'h1;
        end
      end
    end

    // Manual bias write overrides any automatic change in the same cycle
    if (reg_we_in && reg_addr_in == `OBT_REG_BIAS) begin
      nxt_st.bias = reg_wdata_in[3:0];
    end

    nxt_st.rdata = 32'h00000000;
    if (reg_re_in) begin
      case (reg_addr_in)
        `OBT_REG_STATUS: nxt_st.rdata = {26'h0000000, st_ff.state != OBT_HOLD, st_ff.failed,
                                         st_ff.locked, st_ff.enable, 2'h0};
        `OBT_REG_BIAS: nxt_st.rdata = {28'h0000000, st_ff.bias};
        `OBT_REG_CTRL_WORD: nxt_st.rdata = ctrl_word;
        `OBT_REG_HK: nxt_st.rdata = {16'h0000, hk_word};
        `OBT_REG_PHASE: nxt_st.rdata = {20'h00000, st_ff.phase_last};
        `OBT_REG_CMD_COUNT: nxt_st.rdata = {16'h0000, st_ff.cmd_rejected, st_ff.cmd_accepted};
        default: nxt_st.rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      st_ff <= RESET_REGS;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign reg_rdata_out = st_ff.rdata;
  assign sensor_unit_control_word_out = ctrl_word;
  assign control_word_housekeeping_readback_out = hk_word;
  assign auto_tune_enable_parameter_out = st_ff.enable;
  assign cal_go_out = st_ff.cal_go;
  assign search_busy_out = st_ff.state != OBT_HOLD;

endmodule

/* File: src/obt_map.svh */
// Constants for the oscillator bias lock tuner: packet fields, bias values,
// lock window, timing and register offsets.
// Assumes it is included by bare name.
`ifndef OBT_MAP_SVH
`define OBT_MAP_SVH

`define OBT_APID 7'h47
`define OBT_CATEGORY 4'hc
`define OBT_SEQ_SOURCE 3'h0
`define OBT_PKT_LENGTH 16'h0007
`define OBT_ACK 4'h1
`define OBT_PKT_TYPE 8'hc0
`define OBT_PKT_SUBTYPE 8'h15
`define OBT_WORDS 3'h7
`define OBT_LAST_WORD 3'h6

`define OBT_ENABLE_RESET 1'h1
`define OBT_BIAS_RESET 4'h4
`define OBT_BIAS_START 4'h3
`define OBT_BIAS_FAIL 4'h4
`define OBT_BIAS_MAX 4'hf
`define OBT_BIAS_MIN 4'h0
`define OBT_MAX_ITER 6'h20

`define OBT_WIN_LOW 12'h680
`define OBT_WIN_HIGH 12'hb80

`define OBT_CLK_HZ 20000000
`define OBT_SETTLE_MS 1000
`define OBT_MS_PER_S 1000

`define OBT_CW_BIAS_LSB 16
`define OBT_HK_BIAS_MSB 15

`define OBT_REG_STATUS 8'h00
`define OBT_REG_BIAS 8'h04
`define OBT_REG_CTRL_WORD 8'h08
`define OBT_REG_HK 8'h0c
`define OBT_REG_PHASE 8'h10
`define OBT_REG_CMD_COUNT 8'h14

`endif

/* File: src/obt_pkg.sv */
// Types for the oscillator bias lock tuner.
// Assumes obt_map.svh is on the include path.
package obt_pkg;

  typedef enum logic [2:0] {
    OBT_WAIT_INIT,
    OBT_STEP,
    OBT_SETTLE,
    OBT_SAMPLE,
    OBT_HOLD
  } obt_state_t;

  typedef struct packed {
    obt_state_t state;
    logic [3:0] bias;
    logic enable;
    logic [5:0] iter;
    logic [24:0] settle_cnt;
    logic [11:0] phase_meta;
    logic [11:0] phase_sync;
    logic [11:0] phase_last;
    logic locked;
    logic failed;
    logic [2:0] word_idx;
    logic cmd_ok;
    logic cmd_value;
    logic [7:0] cmd_accepted;
    logic [7:0] cmd_rejected;
    logic cal_go;
    logic [31:0] rdata;
  } obt_regs_t;

endpackage

/* File: bench/obt_cmd_src.sv */
// Ground command source for the bias tuner.
// Assumes send is called on the tuner clock.
`timescale 1ns/1ps
`include "obt_map.svh"
module obt_cmd_src (
  input wire logic core_clk_in,
  output logic [15:0] cmd_word_out,
  output logic cmd_valid_out,
  output logic cmd_first_out
);
  logic [10:0] seq = 11'h0;
  // One flipped bit per checked word
  logic [15:0] m [6] = '{16'h0010, 16'h0800, 16'h0001, 16'h0100, 16'h0100, 16'h0002};
  initial begin
    cmd_word_out = 16'h0;
    cmd_valid_out = 1'b0;
    cmd_first_out = 1'b0;
  end
  task automatic send(input logic v, input int bad, input logic [15:0] ck);
    logic [15:0] w [7];
    w = '{{5'h03, `OBT_APID, `OBT_CATEGORY}, {2'h3, `OBT_SEQ_SOURCE, seq}, `OBT_PKT_LENGTH,
      {4'h1, `OBT_ACK, `OBT_PKT_TYPE}, {`OBT_PKT_SUBTYPE, 8'h0}, {15'h0, v}, ck};
    if (bad < 6) w[bad] = w[bad] ^ m[bad];
    for (int i = 0; i < 7; i++) begin
      @(posedge core_clk_in);
      cmd_word_out <= w[i];
      cmd_valid_out <= 1'b1;
      cmd_first_out <= (i == 0);
    end
    @(posedge core_clk_in);
    cmd_valid_out <= 1'b0;
    cmd_first_out <= 1'b0;
    // Released bus must not look like the last word
    cmd_word_out <= ~w[6];
    seq <= seq + 11'h1;
  endtask
endmodule

/* File: bench/obt_tuner_monitor.sv */
// Port checker for the bias tuner.
// Assumes it is bound onto obt_tuner, one clock.
`timescale 1ns/1ps
module obt_tuner_monitor (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic cmd_word_valid_in,
  input wire logic [11:0] phase_err_in,
  input wire logic cal_req_in,
  input wire logic cts_powered_in,
  input wire logic reg_we_in,
  input wire logic [31:0] sensor_unit_control_word_out,
  input wire logic [15:0] control_word_housekeeping_readback_out,
  input wire logic auto_tune_enable_parameter_out,
  input wire logic cal_go_out,
  input wire logic search_busy_out
);
  wire logic [3:0] b = sensor_unit_control_word_out[19:16];
  wire logic [27:0] rest = {sensor_unit_control_word_out[31:20], sensor_unit_control_word_out[15:0]};
  wire logic en = auto_tune_enable_parameter_out;
  wire logic tok = !search_busy_out && en && cts_powered_in && !reg_we_in;
  wire logic idle = !search_busy_out && !reg_we_in && !cal_req_in;
  function automatic logic [3:0] trim(logic [3:0] v, logic [11:0] p);
    if (p < 12'h680) return (v == 4'h0) ? v : v - 4'h1;
    if (p > 12'hb80) return (v == 4'hf) ? v : v + 4'h1;
    return v;
  endfunction
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  a_reset_state: assert property ($fell(rst_in) |-> b == 4'h4 && en && search_busy_out)
    else $error("reset state wrong");
  a_word_map: assert property (rest == 28'h0 &&
    control_word_housekeeping_readback_out == {b[0], b[1], b[2], b[3], 12'h0}) else $error("bias map wrong");
  a_cal_pulse: assert property (cal_go_out == $past(cal_req_in)) else $error("cal go wrong");
  a_trim_rule: assert property (cal_go_out && $past(tok) |->
    b == trim($past(b), $past(phase_err_in, 3))) else $error("trim wrong");
  a_bias_hold: assert property ($past(idle) |-> $stable(b)) else $error("bias moved");
  a_enable_cause: assert property ($changed(en) |-> $past(cmd_word_valid_in)) else $error("enable moved");
  a_hold_sticky: assert property (!$past(search_busy_out) |-> !search_busy_out)
    else $error("search restarted");
  a_lock_keep: assert property ($fell(search_busy_out) && $past(phase_err_in, 3) >= 12'h680 &&
    $past(phase_err_in, 3) <= 12'hb80 |-> $stable(b)) else $error("lock moved bias");
endmodule
bind obt_tuner obt_tuner_monitor u_mon (.core_clk_in, .rst_in, .cmd_word_valid_in, .phase_err_in,
  .cal_req_in, .cts_powered_in, .reg_we_in, .sensor_unit_control_word_out,
  .control_word_housekeeping_readback_out, .auto_tune_enable_parameter_out, .cal_go_out, .search_busy_out);

/* File: bench/oscillator_bias_lock_tuner_tb.sv */
// Self-checking bench for the bias tuner.
// Assumes obt_cmd_src as command source; settle cut to 6 cycles.
`timescale 1ns/1ps
module oscillator_bias_lock_tuner_tb;
  logic core_clk_in = 0, rst_in = 1, tir = 0, cal = 0, pwr = 1, we = 0, re = 0;
  logic [11:0] ph = 12'h100, p;
  logic [7:0] ad = 0;
  logic [3:0] b;
  logic [31:0] wd = 0;
  logic [15:0] r = 16'd29;
  wire logic [15:0] cw, hk;
  wire logic cv, cf, en, go, busy;
  wire logic [31:0] rdo, cwo;
  int mismatches = 0, n_checks = 0, cyc = 0;
  logic [3:0] cb [4] = '{4'h0, 4'hf, 4'h7, 4'h7};
  logic [11:0] cp [4] = '{12'h000, 12'hfff, 12'h680, 12'hb80};
  obt_cmd_src u_src (.core_clk_in, .cmd_word_out(cw), .cmd_valid_out(cv), .cmd_first_out(cf));
  obt_tuner #(.SETTLE_CYCLES(6)) u_dut (.core_clk_in, .rst_in, .cmd_word_in(cw), .cmd_word_valid_in(cv),
    .cmd_first_in(cf), .phase_err_in(ph), .table_init_done_in(tir), .cal_req_in(cal), .cts_powered_in(pwr),
    .reg_addr_in(ad), .reg_wdata_in(wd), .reg_we_in(we), .reg_re_in(re), .reg_rdata_out(rdo),
    .sensor_unit_control_word_out(cwo), .control_word_housekeeping_readback_out(hk),
    .auto_tune_enable_parameter_out(en), .cal_go_out(go), .search_busy_out(busy));
  initial forever #25 core_clk_in = ~core_clk_in;
  function automatic logic [15:0] lfsr(logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [31:0] ecw(logic [3:0] v, logic [11:0] q, logic ok);
    if (ok && q < 12'h680 && v != 4'h0) v = v - 4'h1;
    else if (ok && q > 12'hb80 && v != 4'hf) v = v + 4'h1;
    return {12'h0, v, 16'h0};
  endfunction
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task results;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task rw(input logic [7:0] a, input logic [31:0] d, input logic rd);
    @(posedge core_clk_in);
    ad <= a;
    wd <= d;
    we <= !rd;
    re <= rd;
    @(posedge core_clk_in);
    we <= 0;
    re <= 0;
    #1 if (rd) chk(rdo, d);
  endtask
  task wt(input logic [3:0] v, input logic hold);
    repeat (400) begin
      @(posedge core_clk_in);
      #1 if (hold ? busy === 1'b0 : cwo[19:16] === v) break;
    end
    chk(cwo, {12'h0, v, 16'h0});
  endtask
  task init(input logic [11:0] q);
    @(posedge core_clk_in);
    ph <= q;
    tir <= 1;
    @(posedge core_clk_in);
    tir <= 0;
    #1 chk(cwo, 32'h00030000);
  endtask
  always @(posedge core_clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      $display("mismatch at %0t: timeout", $time);
      results;
    end
  end
  initial begin
    repeat (20) @(posedge core_clk_in);
    rst_in <= 0;
    #1 chk(cwo, 32'h00040000);
    chk({16'h0, hk}, 32'h2000);
    chk({30'h0, en, busy}, 32'h3);
    rw(8'h40, 32'h0, 1);
    for (int i = 0; i < 6; i++) begin
      u_src.send(0, i, r);
      #1 chk({31'h0, en}, 32'h1);
    end
    u_src.send(0, 7, r);
    #1 chk({31'h0, en}, 32'h0);
    u_src.send(1, 7, r);
    #1 chk({31'h0, en}, 32'h1);
    rw(8'h14, 32'h0602, 1);
    $display("test commands done");
    init({2'h0, r[9:0]});
    wt(4'hf, 0);
    wt(4'h0, 0);
    wt(4'h4, 1);
    rw(8'h00, 32'h14, 1);
    $display("test failed search done");
    for (int i = 0; i < 16; i++) begin
      b = (i < 4) ? cb[i] : r[3:0];
      p = (i < 4) ? cp[i] : r[15:4];
      if (i == 10) u_src.send(0, 7, r);
      rw(8'h04, {28'h0, b}, 0);
      @(posedge core_clk_in);
      ph <= p;
      pwr <= (i < 4) | r[0];
      repeat (3) @(posedge core_clk_in);
      cal <= 1;
      @(posedge core_clk_in);
      cal <= 0;
      #1 chk({31'h0, go}, 32'h1);
      chk(cwo, ecw(b, p, i < 10 && pwr));
      r = lfsr(r);
    end
    $display("test trim done");
    @(posedge core_clk_in);
    rst_in <= 1;
    repeat (5) @(posedge core_clk_in);
    rst_in <= 0;
    #1 chk({31'h0, en}, 32'h1);
    init(12'hc00);
    wt(4'h7, 0);
    @(posedge core_clk_in);
    ph <= 12'h800;
    wt(4'h7, 1);
    rw(8'h00, 32'h0c, 1);
    rw(8'h08, 32'h00070000, 1);
    rw(8'h0c, 32'h0000e000, 1);
    rw(8'h10, 32'h00000800, 1);
    $display("test lock done");
    results;
  end
endmodule
